/* common/swt_regs.svh */
// named constants for the single-wire sensor slave
// assumes a 100 MHz clock and a microsecond tick built from it
`ifndef SWT_REGS_SVH
`define SWT_REGS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SWT_CLK_KHZ       100000
`define SWT_CYC_PER_US    (`SWT_CLK_KHZ / 1000)
`define SWT_RST_LOW_US    480
`define SWT_PRES_WAIT_US  30
`define SWT_PRES_LEN_US   120
`define SWT_HOLD_US       15
`define SWT_SAMPLE_US     30
`define SWT_TCONV_MS      750
// ----------------------------------------
// command codes
// ----------------------------------------
`define SWT_CMD_READ_ID   8'h33
`define SWT_CMD_MATCH     8'h55
`define SWT_CMD_SKIP      8'hcc
`define SWT_CMD_SEARCH    8'hf0
`define SWT_CMD_ALARM     8'hec
`define SWT_FN_WRITE      8'h4e
`define SWT_FN_READ       8'hbe
`define SWT_FN_COPY       8'h48
`define SWT_FN_CONV       8'h44
`define SWT_FN_RECALL     8'hb8
`define SWT_FN_POWER      8'hb4
// ----------------------------------------
// scratchpad map and field values
// ----------------------------------------
`define SWT_OFF_HIGH_TRIG 4'h2
`define SWT_OFF_LOW_TRIG  4'h3
`define SWT_OFF_RES_SETUP 4'h4
`define SWT_OFF_CHECK     4'h8
`define SWT_CFG_ONES      5'h1f
`define SWT_RES_LSB       5
`define SWT_RES_RESET     2'h3
`define SWT_TEMP_RESET    16'h0550
`define SWT_TH_RESET      8'h4b
`define SWT_TL_RESET      8'h46
`define SWT_INT_A         8'hff
`define SWT_INT_B         8'h00
`define SWT_INT_C         8'h10
`define SWT_CRC_POLY      8'h8c
`define SWT_BYTE_LAST     3'h7
`define SWT_ROM_LAST      7'h3f
`define SWT_PAD_LAST      7'h47
`endif

/* common/swt_pkg.sv */
// types used inside the single-wire sensor slave
// assumes swt_regs.svh for the numeric constants
package swt_pkg;
  // gray steps along idle, presence, command, function, data
  typedef enum logic [3:0] {
    SWT_IDLE   = 4'h0,
    SWT_PRES   = 4'h1,
    SWT_CMD    = 4'h3,
    SWT_FUNC   = 4'h2,
    SWT_DATA   = 4'h6,
    SWT_ROM_TX = 4'h7,
    SWT_MATCH  = 4'h5,
    SWT_SEARCH = 4'h4,
    SWT_WAIT   = 4'hc
  } swt_state_t;

  // trigger bytes and resolution, as scratchpad or nonvolatile copy
  typedef struct packed {
    logic [7:0] th;
    logic [7:0] tl;
    logic [1:0] res;
  } swt_trig_t;
endpackage

/* design/swt_rom_layer.sv */
// slave end of a single-wire temperature sensor: line timing,
// identity commands, search, scratchpad and conversion control.
// assumes dq_in already synchronous; a pullup outside the block.
//
// What this block does
// - config reads ones low, zero top bit
// - two resolution bits pick 9 to 12
// - conversion time halves per resolution step down
// - nonvolatile resolution starts at twelve bits
// - line idles high, any recovery allowed
// - line low past 480 us resets protocol
// - reset, identity command, function, then data
// - master reset pulse answered by presence
// - identity commands are eight bits long
// - command 33h sends family, serial, check
// - command 55h selects only on full match
// - command CCh selects without identity
// - search sends bit, complement, reads choice
// - mismatched search choice drops device out
// - command ECh searches only while alarmed
// - alarm when outside nonvolatile triggers
// - zero pulls low, one releases line
// - master starts every slot but presence
// - presence after 15-60 us, 60-240 long
// - nine byte scratchpad with check byte
// - written bits sampled 15-60 us in
// - check byte x8+x5+x4+1, lsb first
`timescale 1ns/1ps
`include "swt_regs.svh"

module swt_rom_layer #(
  parameter logic [7:0]  FAMILY_CODE = 8'h5a,           // arbitrary value
  parameter logic [47:0] SERIAL_NUM  = 48'h0000_0000_0001, // arbitrary value
  parameter int unsigned CYC_PER_US  = `SWT_CYC_PER_US,
  parameter int unsigned CONV_MAX_US = `SWT_TCONV_MS * 1000
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        dq_in,
  output wire logic        dq_out,
  output wire logic        dq_oe,
  input  wire logic [15:0] temp_in,
  input  wire logic        vdd_present,
  output wire logic        selected,
  output wire logic        alarm_flag,
  output wire logic        conv_busy,
  output wire logic        conv_start
);
  localparam logic [6:0] CYC_LAST   = 7'(CYC_PER_US - 1);
  localparam logic [8:0] RST_US     = 9'(`SWT_RST_LOW_US);
  localparam logic [7:0] PRES_WAIT  = 8'(`SWT_PRES_WAIT_US);
  localparam logic [7:0] PRES_END   = 8'(`SWT_PRES_WAIT_US + `SWT_PRES_LEN_US);
  localparam logic [5:0] HOLD_US    = 6'(`SWT_HOLD_US);
  localparam logic [5:0] SAMPLE_US  = 6'(`SWT_SAMPLE_US);
  localparam logic [1:0] PH_WRITE   = 2'h2;
  localparam swt_pkg::swt_trig_t TRIG_RST = '{`SWT_TH_RESET, `SWT_TL_RESET, `SWT_RES_RESET};

  // ----------------------------------------
  // check byte over a bit stream
  // ----------------------------------------
  function automatic logic [7:0] crc8(input logic [71:0] d, input logic [6:0] n);
    logic [7:0] c;
    logic       fb;
    c = 8'h0;
    for (int i = 0; i < 72; i++) begin
      if (7'(i) < n) begin
        fb = c[0] ^ d[i];
        c = {1'b0, c[7:1]} ^ (fb ? `SWT_CRC_POLY : 8'h0);
      end
    end
    return c;
  endfunction

  // ----------------------------------------
  // line timing state
  // ----------------------------------------
  logic [6:0] div_ff,     nxt_div;
  logic       dq_q_ff,    nxt_dq_q;
  logic [8:0] low_us_ff,  nxt_low_us;
  logic       rst_seen_ff, nxt_rst_seen;
  logic       pres_on_ff, nxt_pres_on;
  logic [7:0] pres_us_ff, nxt_pres_us;
  logic       slot_on_ff, nxt_slot_on;
  logic [5:0] slot_us_ff, nxt_slot_us;
  logic       drive_ff,   nxt_drive;

  // ----------------------------------------
  // protocol state
  // ----------------------------------------
  swt_pkg::swt_state_t state_ff, nxt_state;
  logic [6:0]          bit_ff,      nxt_bit;
  logic [1:0]          phase_ff,    nxt_phase;
  logic [7:0]          sr_ff,       nxt_sr;
  logic                match_ok_ff, nxt_match_ok;
  logic [7:0]          fn_ff,       nxt_fn;
  swt_pkg::swt_trig_t  pad_ff,      nxt_pad;
  swt_pkg::swt_trig_t  nv_ff,       nxt_nv;
  logic [15:0]         temp_ff,     nxt_temp;
  logic                alarm_ff,    nxt_alarm;
  logic                busy_ff,     nxt_busy;
  logic [19:0]         conv_us_ff,  nxt_conv_us;
  logic                start_ff,    nxt_start;

  logic        tick;
  logic        fall;
  logic        rise;
  logic        rst_hit;
  logic        pres_done;
  logic        step;
  logic        active;
  logic        tx_bit;
  logic [55:0] rom_base;
  logic [63:0] rom;
  logic [7:0]  cfg_byte;
  logic [63:0] pad64;
  logic [71:0] pad_rd;
  logic [19:0] conv_lim;
  logic [15:0] res_mask;
  logic [15:0] temp_new;

  assign tick      = div_ff == CYC_LAST;
  assign fall      = dq_q_ff & ~dq_in;
  assign rise      = ~dq_q_ff & dq_in;
  assign rst_hit   = ~dq_in & (low_us_ff == RST_US);
  assign pres_done = pres_on_ff & tick & (pres_us_ff == PRES_END);
  assign step      = slot_on_ff & tick & (slot_us_ff == SAMPLE_US);
  assign active    = (state_ff != swt_pkg::SWT_IDLE) && (state_ff != swt_pkg::SWT_WAIT);

  assign rom_base = {SERIAL_NUM, FAMILY_CODE};
  assign rom      = {crc8(72'(rom_base), 7'h38), rom_base};
  assign cfg_byte = {1'b0, pad_ff.res, `SWT_CFG_ONES};
  assign pad64    = {`SWT_INT_C, `SWT_INT_B, `SWT_INT_A, cfg_byte, pad_ff.tl, pad_ff.th, temp_ff};
  assign pad_rd   = {crc8({8'h0, pad64}, 7'h40), pad64};

  // twelve bits take the full time, each step down halves it
  assign conv_lim = 20'(CONV_MAX_US >> (2'h3 - pad_ff.res));
  assign res_mask = 16'hffff << (2'h3 - pad_ff.res);
  assign temp_new = temp_in & res_mask;

  // ----------------------------------------
  // bit to send in the current read slot
  // ----------------------------------------
  always_comb begin
    tx_bit = 1'b1;
    case (state_ff)
      swt_pkg::SWT_ROM_TX: begin
        tx_bit = rom[bit_ff[5:0]];
      end
      swt_pkg::SWT_SEARCH: begin
        if (phase_ff != PH_WRITE) begin
          tx_bit = rom[bit_ff[5:0]] ^ phase_ff[0];
        end
      end
      swt_pkg::SWT_DATA: begin
        case (fn_ff)
          `SWT_FN_READ:   tx_bit = pad_rd[bit_ff];
          `SWT_FN_CONV:   tx_bit = ~busy_ff;
          `SWT_FN_RECALL: tx_bit = ~busy_ff;
          `SWT_FN_POWER:  tx_bit = vdd_present;
          default:        tx_bit = 1'b1;
        endcase
      end
      default: tx_bit = 1'b1;
    endcase
  end

  // ----------------------------------------
  // line timing: tick, reset detect, presence, slots
  // ----------------------------------------
  always_comb begin
    nxt_div      = tick ? 7'h0 : div_ff + 7'h1;
    nxt_dq_q     = dq_in;
    nxt_low_us   = low_us_ff;
    nxt_rst_seen = rst_seen_ff;
    nxt_pres_on  = pres_on_ff;
    nxt_pres_us  = pres_us_ff;
    nxt_slot_on  = slot_on_ff;
    nxt_slot_us  = slot_us_ff;
    nxt_drive    = drive_ff;
    // a high line never times out, so recovery may be any length
    if (dq_in) begin
      nxt_low_us = 9'h0;
    end else if (tick && low_us_ff != RST_US) begin
      nxt_low_us = low_us_ff + 9'h1;
    end
    if (rst_hit) begin
      nxt_rst_seen = 1'b1;
    end else if (rise) begin
      nxt_rst_seen = 1'b0;
    end
    if (rst_hit) begin
      nxt_pres_on = 1'b0;
      nxt_slot_on = 1'b0;
      nxt_drive   = 1'b0;
    end else if (rise && rst_seen_ff) begin
      nxt_pres_on = 1'b1;
      nxt_pres_us = 8'h0;
    end else if (pres_on_ff) begin
      if (tick) begin
        nxt_pres_us = pres_us_ff + 8'h1;
      end
      nxt_drive = (pres_us_ff >= PRES_WAIT) && (pres_us_ff < PRES_END);
      if (pres_done) begin
        nxt_pres_on = 1'b0;
      end
    end else if (slot_on_ff) begin
      if (tick) begin
        nxt_slot_us = slot_us_ff + 6'h1;
      end
      if (tick && slot_us_ff == HOLD_US) begin
        nxt_drive = 1'b0;
      end
      if (step) begin
        nxt_slot_on = 1'b0;
      end
    end else if (fall && active) begin
      nxt_slot_on = 1'b1;
      nxt_slot_us = 6'h0;
      nxt_drive   = ~tx_bit;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_ff      <= 7'h0;
      dq_q_ff     <= 1'b1;
      low_us_ff   <= 9'h0;
      rst_seen_ff <= 1'b0;
      pres_on_ff  <= 1'b0;
      pres_us_ff  <= 8'h0;
      slot_on_ff  <= 1'b0;
      slot_us_ff  <= 6'h0;
      drive_ff    <= 1'b0;
    end else begin
      div_ff      <= nxt_div;
      dq_q_ff     <= nxt_dq_q;
      low_us_ff   <= nxt_low_us;
      rst_seen_ff <= nxt_rst_seen;
      pres_on_ff  <= nxt_pres_on;
      pres_us_ff  <= nxt_pres_us;
      slot_on_ff  <= nxt_slot_on;
      slot_us_ff  <= nxt_slot_us;
      drive_ff    <= nxt_drive;
    end
  end

  // ----------------------------------------
  // protocol, scratchpad and conversion
  // ----------------------------------------
  always_comb begin
    logic [7:0] rx_sr;
    logic [3:0] wr_off;
    rx_sr        = {dq_in, sr_ff[7:1]};
    wr_off       = 4'(bit_ff[4:3]) + `SWT_OFF_HIGH_TRIG;
    nxt_state    = state_ff;
    nxt_bit      = bit_ff;
    nxt_phase    = phase_ff;
    nxt_sr       = sr_ff;
    nxt_match_ok = match_ok_ff;
    nxt_fn       = fn_ff;
    nxt_pad      = pad_ff;
    nxt_nv       = nv_ff;
    nxt_temp     = temp_ff;
    nxt_alarm    = alarm_ff;
    nxt_busy     = busy_ff;
    nxt_conv_us  = conv_us_ff;
    nxt_start    = 1'b0;
    if (busy_ff) begin
      if (tick) begin
        nxt_conv_us = conv_us_ff + 20'h1;
      end
      if (conv_us_ff >= conv_lim) begin
        nxt_busy  = 1'b0;
        nxt_temp  = temp_new;
        // upper trigger bits line up with the sign of the result
        nxt_alarm = ($signed(temp_new[11:4]) > $signed(nv_ff.th)) ||
                    ($signed(temp_new[11:4]) < $signed(nv_ff.tl));
      end
    end
    if (rst_hit) begin
      nxt_state = swt_pkg::SWT_IDLE;
    end else if (pres_done) begin
      nxt_state = swt_pkg::SWT_CMD;
      nxt_bit   = 7'h0;
      nxt_phase = 2'h0;
    end else if (step) begin
      nxt_sr  = rx_sr;
      nxt_bit = bit_ff + 7'h1;
      case (state_ff)
        swt_pkg::SWT_CMD: begin
          if (bit_ff[2:0] == `SWT_BYTE_LAST) begin
            nxt_bit      = 7'h0;
            nxt_match_ok = 1'b1;
            case (rx_sr)
              `SWT_CMD_READ_ID: nxt_state = swt_pkg::SWT_ROM_TX;
              `SWT_CMD_MATCH:   nxt_state = swt_pkg::SWT_MATCH;
              `SWT_CMD_SKIP:    nxt_state = swt_pkg::SWT_FUNC;
              `SWT_CMD_SEARCH:  nxt_state = swt_pkg::SWT_SEARCH;
              `SWT_CMD_ALARM:   nxt_state = alarm_ff ? swt_pkg::SWT_SEARCH : swt_pkg::SWT_WAIT;
              default:          nxt_state = swt_pkg::SWT_WAIT;
            endcase
          end
        end
        swt_pkg::SWT_ROM_TX: begin
          if (bit_ff == `SWT_ROM_LAST) begin
            nxt_state = swt_pkg::SWT_FUNC;
            nxt_bit   = 7'h0;
          end
        end
        swt_pkg::SWT_MATCH: begin
          nxt_match_ok = match_ok_ff & (dq_in == rom[bit_ff[5:0]]);
          if (bit_ff == `SWT_ROM_LAST) begin
            nxt_state = nxt_match_ok ? swt_pkg::SWT_FUNC : swt_pkg::SWT_WAIT;
            nxt_bit   = 7'h0;
          end
        end
        swt_pkg::SWT_SEARCH: begin
          nxt_bit = bit_ff;
          if (phase_ff != PH_WRITE) begin
            nxt_phase = phase_ff + 2'h1;
          end else begin
            nxt_phase = 2'h0;
            nxt_bit   = bit_ff + 7'h1;
            if (dq_in != rom[bit_ff[5:0]]) begin
              nxt_state = swt_pkg::SWT_WAIT;
            end else if (bit_ff == `SWT_ROM_LAST) begin
              nxt_state = swt_pkg::SWT_FUNC;
              nxt_bit   = 7'h0;
            end
          end
        end
        swt_pkg::SWT_FUNC: begin
          if (bit_ff[2:0] == `SWT_BYTE_LAST) begin
            nxt_fn    = rx_sr;
            nxt_bit   = 7'h0;
            nxt_state = swt_pkg::SWT_DATA;
            case (rx_sr)
              `SWT_FN_CONV: begin
                nxt_busy    = 1'b1;
                nxt_conv_us = 20'h0;
                nxt_start   = 1'b1;
              end
              `SWT_FN_COPY:   nxt_nv  = pad_ff;
              `SWT_FN_RECALL: nxt_pad = nv_ff;
              `SWT_FN_WRITE:  nxt_pad = pad_ff;
              `SWT_FN_READ:   nxt_pad = pad_ff;
              `SWT_FN_POWER:  nxt_pad = pad_ff;
              default:        nxt_state = swt_pkg::SWT_WAIT;
            endcase
          end
        end
        swt_pkg::SWT_DATA: begin
          if (fn_ff == `SWT_FN_WRITE && bit_ff[2:0] == `SWT_BYTE_LAST) begin
            case (wr_off)
              `SWT_OFF_HIGH_TRIG: nxt_pad.th = rx_sr;
              `SWT_OFF_LOW_TRIG:  nxt_pad.tl = rx_sr;
              `SWT_OFF_RES_SETUP: begin
                // only the resolution pair is kept, the rest reads fixed
                nxt_pad.res = rx_sr[`SWT_RES_LSB +: 2];
                nxt_state   = swt_pkg::SWT_WAIT;
              end
              default: nxt_state = swt_pkg::SWT_WAIT;
            endcase
          end else if (fn_ff == `SWT_FN_READ && bit_ff == `SWT_PAD_LAST) begin
            nxt_state = swt_pkg::SWT_WAIT;
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff    <= swt_pkg::SWT_IDLE;
      bit_ff      <= 7'h0;
      phase_ff    <= 2'h0;
      sr_ff       <= 8'h0;
      match_ok_ff <= 1'b0;
      fn_ff       <= 8'h0;
      pad_ff      <= TRIG_RST;
      nv_ff       <= TRIG_RST;
      temp_ff     <= `SWT_TEMP_RESET;
      alarm_ff    <= 1'b0;
      busy_ff     <= 1'b0;
      conv_us_ff  <= 20'h0;
      start_ff    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      bit_ff      <= nxt_bit;
      phase_ff    <= nxt_phase;
      sr_ff       <= nxt_sr;
      match_ok_ff <= nxt_match_ok;
      fn_ff       <= nxt_fn;
      pad_ff      <= nxt_pad;
      nv_ff       <= nxt_nv;
      temp_ff     <= nxt_temp;
      alarm_ff    <= nxt_alarm;
      busy_ff     <= nxt_busy;
      conv_us_ff  <= nxt_conv_us;
      start_ff    <= nxt_start;
    end
  end

  // open drain: the pin only ever pulls low
  assign dq_out     = 1'b0;
  assign dq_oe      = drive_ff;
  assign selected   = (state_ff == swt_pkg::SWT_FUNC) || (state_ff == swt_pkg::SWT_DATA);
  assign alarm_flag = alarm_ff;
  assign conv_busy  = busy_ff;
  assign conv_start = start_ff;

endmodule

/* test/swt_rom_layer_assertions.sv */
// port checker for the single-wire sensor slave
// assumes CYC_PER_US clocks per microsecond and the resolved line level on dq_in
`timescale 1ns/1ps
module swt_rom_layer_checker #(
  parameter int unsigned CONV_MAX_US = 750000,
  parameter int unsigned CYC_PER_US  = 100
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        dq_in,
  input wire logic        dq_out,
  input wire logic        dq_oe,
  input wire logic [15:0] temp_in,
  input wire logic        vdd_present,
  input wire logic        selected,
  input wire logic        alarm_flag,
  input wire logic        conv_busy,
  input wire logic        conv_start
);
  // ------
  // run lengths of line levels and outputs
  // ------
  // the 16-bit counts saturate so a parked line never wraps into a false pass
  localparam int unsigned BUSY_MIN = (CONV_MAX_US / 8 - 2) * CYC_PER_US;
  localparam int unsigned BUSY_MAX = (CONV_MAX_US + 2) * CYC_PER_US;
  localparam int unsigned PRES_MIN = 15 * CYC_PER_US;
  localparam int unsigned PRES_MAX = 60 * CYC_PER_US;
  localparam int unsigned OE_MIN   = 13 * CYC_PER_US;
  localparam int unsigned OE_MAX   = 240 * CYC_PER_US;
  localparam int unsigned LONG_LOW = 483 * CYC_PER_US;
  logic [15:0] lo_ff, hi_ff, oe_ff;
  logic [31:0] busy_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lo_ff   <= 16'h0;
      hi_ff   <= 16'h0;
      oe_ff   <= 16'h0;
      busy_ff <= 32'h0;
    end else begin
      lo_ff   <= dq_in ? 16'h0 : lo_ff + {15'h0, ~&lo_ff};
      hi_ff   <= dq_in ? hi_ff + {15'h0, ~&hi_ff} : 16'h0;
      oe_ff   <= dq_oe ? oe_ff + {15'h0, ~&oe_ff} : 16'h0;
      busy_ff <= conv_busy ? busy_ff + 32'h1 : 32'h0;
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_open_drain; dq_oe |-> dq_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  // 15 to 60 us of high line before presence
  property p_pres_delay; $rose(dq_oe) && $past(dq_in) |-> $past(hi_ff) >= PRES_MIN && $past(hi_ff) <= PRES_MAX;
  endproperty
  a_pres_delay: assert property (p_pres_delay) else $error("presence delay off");
  property p_slot_start; $rose(dq_oe) && !$past(dq_in) |-> $past(lo_ff) <= 16'h0003; endproperty
  a_slot_start: assert property (p_slot_start) else $error("device started a slot");
  // 13 to 240 us of pull-down
  property p_oe_len; $fell(dq_oe) |-> $past(oe_ff) >= OE_MIN && $past(oe_ff) <= OE_MAX; endproperty
  a_oe_len: assert property (p_oe_len) else $error("pull-down length off");
  property p_long_low; lo_ff >= LONG_LOW |-> !selected && !dq_oe; endproperty
  a_long_low: assert property (p_long_low) else $error("no reset on long low");
  property p_conv_start; conv_start |=> conv_busy && !conv_start; endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion did not start");
  property p_conv_len; $fell(conv_busy) |-> $past(busy_ff) >= BUSY_MIN && $past(busy_ff) <= BUSY_MAX; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length off");
  property p_alarm_hold; $changed(alarm_flag) |-> !conv_busy && ($past(conv_busy) || $past(conv_busy, 2)); endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm moved outside conversion end");
endmodule

bind swt_rom_layer swt_rom_layer_checker #(.CONV_MAX_US(CONV_MAX_US), .CYC_PER_US(CYC_PER_US))
  swt_rom_layer_checker_inst (
  .clock(clock), .rst(rst), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .temp_in(temp_in),
  .vdd_present(vdd_present), .selected(selected), .alarm_flag(alarm_flag), .conv_busy(conv_busy),
  .conv_start(conv_start)
);

/* test/swt_line_master.sv */
// bus master model for the single-wire line of the sensor slave
// assumes a 100 MHz clock and a pullup that lifts the released line
`timescale 1ns/1ps
module swt_line_master #(
  parameter int CYC_PER_US = 100
) (
  input  wire logic clock,
  input  wire logic dq_in,
  output logic      pull
);
  // ------
  // slot timing, every change just after a falling edge
  // ------
  initial pull = 1'b0;
  task automatic us(input int n);
    repeat (n * CYC_PER_US) @(negedge clock);
  endtask
  // release leaves the line idle high for any recovery time
  task automatic line_reset(output logic seen);
    pull = 1'b1;
    us(490);
    pull = 1'b0;
    us(70);
    seen = ~dq_in;
    us(90);
  endtask
  // a zero stays low past the sample point, a one lets go early
  task automatic wr_bit(input logic b);
    pull = 1'b1;
    us(b ? 2 : 60);
    pull = 1'b0;
    us(b ? 59 : 1);
  endtask
  task automatic wr_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) wr_bit(v[i]);
  endtask
  // sampled at 13 us, before the device may let go
  task automatic rd_bit(output logic b);
    pull = 1'b1;
    us(1);
    pull = 1'b0;
    us(12);
    b = dq_in;
    us(48);
  endtask
  task automatic rd_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) rd_bit(v[i]);
  endtask
endmodule

/* test/test_swt_rom_layer.sv */
// self-checking bench for the single-wire sensor slave
// assumes the line master model and the bound port checker
`timescale 1ns/1ps
`include "swt_regs.svh"
module test_swt_rom_layer;
  localparam logic [7:0]  FAM     = 8'h5a;              // arbitrary value
  localparam logic [47:0] SER     = 48'h0000_0000_0001; // arbitrary value
  localparam int          CONV_US = 200;
  localparam int          CYC     = 1; // one clock per microsecond tick keeps the run short
  logic        clock, rst, dq_in, dq_out, dq_oe, pull, vdd_present;
  logic        selected, alarm_flag, conv_busy, conv_start;
  logic [15:0] temp_in;
  logic [63:0] id;
  int          n_errors, n_tests, busy_cyc;
  // ------
  // line, clock and instances
  // ------
  assign dq_in = ~pull & ~(dq_oe & ~dq_out);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (conv_busy === 1'b1) busy_cyc <= busy_cyc + 1;
  swt_rom_layer #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .CYC_PER_US(CYC), .CONV_MAX_US(CONV_US)) swt_rom_layer_inst (
    .clock(clock), .rst(rst), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .temp_in(temp_in),
    .vdd_present(vdd_present), .selected(selected), .alarm_flag(alarm_flag), .conv_busy(conv_busy),
    .conv_start(conv_start));
  swt_line_master #(.CYC_PER_US(CYC)) swt_line_master_inst (.clock(clock), .dq_in(dq_in), .pull(pull));
  // ------
  // helpers
  // ------
  function automatic logic [7:0] crc_of(input logic [71:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? `SWT_CRC_POLY : 8'h00);
    return c;
  endfunction
  assign id = {crc_of({16'h0, SER, FAM}, 56), SER, FAM};
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic start(input logic [7:0] cmd);
    logic seen;
    swt_line_master_inst.line_reset(seen);
    chk1("presence", 1'b1, seen);
    swt_line_master_inst.wr_byte(cmd);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_pad(input logic [15:0] temp, input logic [7:0] th, input logic [7:0] tl, input logic [7:0] cfg);
    logic [71:0] exp;
    logic [7:0]  got;
    exp[63:0] = {`SWT_INT_C, `SWT_INT_B, `SWT_INT_A, cfg, tl, th, temp};
    exp[71:64] = crc_of(exp, 64);
    start(`SWT_CMD_SKIP);
    swt_line_master_inst.wr_byte(`SWT_FN_READ);
    for (int k = 0; k < 9; k++) begin
      swt_line_master_inst.rd_byte(got);
      chk16("scratchpad byte", {8'h0, exp[8*k +: 8]}, {8'h0, got});
    end
  endtask
  task automatic t_read_id;
    logic [63:0] got;
    start(`SWT_CMD_READ_ID);
    for (int k = 0; k < 64; k++) swt_line_master_inst.rd_bit(got[k]);
    for (int k = 0; k < 4; k++) chk16("identity", id[16*k +: 16], got[16*k +: 16]);
    chk1("selected after identity", 1'b1, selected);
  endtask
  task automatic t_match(input logic good);
    logic [63:0] code;
    logic [7:0]  got;
    code = id ^ {~good, 63'h0};
    start(`SWT_CMD_MATCH);
    for (int k = 0; k < 8; k++) swt_line_master_inst.wr_byte(code[8*k +: 8]);
    chk1("selected after match", good, selected);
    swt_line_master_inst.wr_byte(`SWT_FN_READ);
    swt_line_master_inst.rd_byte(got);
    chk16("byte after match", {8'h0, good ? 8'h50 : 8'hff}, {8'h0, got});
  endtask
  // drop writes the wrong choice at the first two positions
  task automatic t_search(input logic [7:0] cmd, input logic live, input logic drop);
    logic a, b;
    start(cmd);
    for (int i = 0; i < 64; i++) begin
      if (!live && i > 1) break;
      swt_line_master_inst.rd_bit(a);
      swt_line_master_inst.rd_bit(b);
      chk1("search bit", live ? id[i] : 1'b1, a);
      chk1("search complement", live ? ~id[i] : 1'b1, b);
      swt_line_master_inst.wr_bit(id[i] ^ drop);
      live = live & ~drop;
    end
    chk1("selected after search", live, selected);
  endtask
  task automatic convert(input int exp_cyc);
    start(`SWT_CMD_SKIP);
    busy_cyc = 0;
    swt_line_master_inst.wr_byte(`SWT_FN_CONV);
    for (int k = 0; k < 30000 && conv_busy === 1'b1; k++) @(negedge clock);
    if (conv_busy !== 1'b0) begin
      n_errors++;
      finish_test();
    end
    chk1("conversion time", 1'b1, busy_cyc > exp_cyc - 2 * CYC && busy_cyc < exp_cyc + 2 * CYC);
  endtask
  // don't-care bits written inverted to prove they are ignored
  task automatic t_resolution(input logic [1:0] res);
    start(`SWT_CMD_SKIP);
    swt_line_master_inst.wr_byte(`SWT_FN_WRITE);
    swt_line_master_inst.wr_byte(8'h50);
    swt_line_master_inst.wr_byte(8'h10);
    swt_line_master_inst.wr_byte({1'b1, res, 5'h00});
    convert((CONV_US >> (3 - res)) * CYC);
    t_pad(temp_in & ~((16'h1 << (3 - res)) - 16'h1), 8'h50, 8'h10, {1'b0, res, 5'h1f});
  endtask
  task automatic t_alarm;
    logic [15:0] temps [3] = '{16'h07d0, 16'h0480, 16'h0100};
    logic        alarms [3] = '{1'b1, 1'b0, 1'b1};
    for (int k = 0; k < 3; k++) begin
      temp_in = temps[k];
      convert(CONV_US * CYC);
      chk1("alarm flag", alarms[k], alarm_flag);
    end
  endtask
  task automatic t_line_reset;
    logic seen;
    start(`SWT_CMD_SKIP);
    chk1("selected after skip", 1'b1, selected);
    swt_line_master_inst.line_reset(seen);
    chk1("selected after long low", 1'b0, selected);
    chk1("presence after long low", 1'b1, seen);
  endtask
  // new triggers stored while alarmed, then a fresh conversion clears it
  task automatic t_copy;
    logic b;
    start(`SWT_CMD_SKIP);
    swt_line_master_inst.wr_byte(`SWT_FN_COPY);
    vdd_present = 1'b0;
    start(`SWT_CMD_SKIP);
    swt_line_master_inst.wr_byte(`SWT_FN_POWER);
    swt_line_master_inst.rd_bit(b);
    chk1("power mode", 1'b0, b);
    convert(CONV_US * CYC);
    chk1("alarm after copy", 1'b0, alarm_flag);
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    rst = 1'b1;
    temp_in = 16'h0191;
    vdd_present = 1'b1;
    n_errors = 0;
    n_tests = 0;
    busy_cyc = 0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    t_pad(`SWT_TEMP_RESET, `SWT_TH_RESET, `SWT_TL_RESET, 8'h7f);
    t_read_id();
    t_match(1'b0);
    t_match(1'b1);
    t_search(`SWT_CMD_SEARCH, 1'b1, 1'b0);
    t_search(`SWT_CMD_SEARCH, 1'b1, 1'b1);
    t_search(`SWT_CMD_ALARM, 1'b0, 1'b0);
    for (int r = 0; r < 4; r++) t_resolution(r[1:0]);
    t_search(`SWT_CMD_ALARM, 1'b1, 1'b0);
    t_alarm();
    t_copy();
    t_line_reset();
    finish_test();
  end
endmodule
